// >>> dv/nfh_flash_mdl.sv
// Behavioural flash device as seen from the host pins
`default_nettype none
module nfh_flash_mdl
    import nfh_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h3c
)
(
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    input  wire logic              reset_n,
    input  wire logic              byte_n,
    input  wire logic              boost,
    input  wire logic              hv9,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic      [37:0]       cmd_r,
    output logic                   shortcut
);
    timeunit 1ns;
    timeprecision 100ps;
    realtime           t_a  = 0.0;
    realtime           t_oe = 0.0;
    logic              pg_ok = 1'b0;
    logic [18:0]       pg_r;
    logic [DATA_W-1:0] d;
    initial dq_out = 16'h0;
    assign shortcut = boost;
    always @(addr) t_a = $realtime;
    // Byte lane select is an address input only in byte mode
    always @(dq_in[15]) if (!byte_n) t_a = $realtime;
    always @(negedge oe_n) t_oe = $realtime;
    // page opened by a finished read
    always @(posedge oe_n) if (!ce_n) {pg_ok, pg_r} = {1'b1, addr[21:3]};
    always @(posedge ce_n or negedge reset_n) pg_ok = 1'b0;
    always @(posedge we_n) if (!ce_n && reset_n) cmd_r = {addr, dq_in};
    always #1
    begin
        d = hv9 ? {8'h00, ID_CODE} : addr[15:0] ^ 16'hc3a5 ^ {addr[21:16], 10'h000};
        if (!byte_n && dq_in[15])
            d = {8'h00, d[15:8]};
        if (ce_n || oe_n || !reset_n)
            dq_out = ~dq_out;
        else if ($realtime - t_oe < OUTEN_TO_DATA_NS || $realtime - t_a <
                 ((pg_ok && addr[21:3] == pg_r) ? IN_PAGE_NS : ADDR_TO_DATA_NS))
            dq_out = ~d;
        else
            dq_out = byte_n ? d : {~dq_out[15:8], d[7:0]};
    end
endmodule
`default_nettype wire

// >>> dv/nor_flash_async_bus_port_test.sv
// Self-checking bench of the NOR flash host controller
`default_nettype none
`define chk(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module nor_flash_async_bus_port_test
    import nfh_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value
    logic              clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]        reg_addr = 4'h0;
    logic [31:0]       reg_wdata = 32'h0, reg_rdata, rv;
    logic              ce_n, oe_n, we_n, frst_n, byte_n, boost, wp_n, hv9, sc;
    logic              pce = 1'b1, pw = 1'b1;
    logic [ADDR_W-1:0] fa, a;
    logic [DATA_W-1:0] dq_o, dq_oe, dq_i, dq_m;
    logic [37:0]       cmd;
    int                failures = 0, compares = 0, seed = 32'h8d12;
    always #4 clk = ~clk;
    assign dq_i = (dq_oe & dq_o) | (~dq_oe & dq_m);
    nfh_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_enable_n(ce_n),
        .output_enable_n(oe_n), .write_enable_n(we_n), .flash_reset_n(frst_n),
        .width_select_n(byte_n), .program_boost_pin(boost), .write_protect_n(wp_n),
        .autoselect_hv_en(hv9), .flash_addr(fa), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
    nfh_flash_mdl #(.ID_CODE(ID_CODE)) mdl_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .reset_n(frst_n), .byte_n(byte_n), .boost(boost), .hv9(hv9), .addr(fa),
        .dq_in(dq_i), .dq_out(dq_m), .cmd_r(cmd), .shortcut(sc));
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= ad;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_done();
        int k;
        for (k = 0; k < 100 && !rv[ST_DONE]; k++)
            rd(REG_STATUS);
        if (!rv[ST_DONE])
        begin
            failures++;
            stop_test();
        end
    endtask
    // Mode 0 word, 1 byte, 2 identification
    task automatic fread(input logic [21:0] ad, input int md, input logic fast);
        logic [15:0] e;
        e = ad[15:0] ^ 16'hc3a5 ^ {ad[21:16], 10'h000};
        wr(REG_ADDR, {10'h0, ad});
        wr(REG_CMD, {30'h0, CMD_READ});
        rv = 32'h0;
        wait_done();
        `chk(rv[ST_FAST], fast);
        rd(REG_RDATA);
        if (md == 0) `chk(rv[15:0], e);
        if (md == 1) `chk(rv[7:0], ad[0] ? e[15:8] : e[7:0]);
        if (md == 2) `chk(rv[7:0], ID_CODE);
    endtask
    always @(posedge clk)
    begin
        if (!rst)
        begin
            if (!we_n) `chk({oe_n, ce_n}, 2'b10);
            if (!oe_n) `chk({we_n, dq_oe}, {1'b1, !byte_n, 15'h0000});
            if (!byte_n) `chk(dq_oe[14:8], 7'h00);
            if (!ce_n && !pce) `chk(byte_n, pw);
            pce <= ce_n;
            pw  <= byte_n;
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 `chk({ce_n, oe_n, we_n, frst_n, byte_n, dq_oe}, 21'h1f0000);
        wr(4'hf, 32'h3f);
        rd(REG_CTRL);
        `chk(rv[5:0], CTRL_RST_VAL);
        repeat (5)
        begin
            a = $random(seed);
            fread(a, 0, 1'b0);
        end
        wr(REG_CTRL, 32'h20);
        fread(a, 0, 1'b0);
        fread(a ^ 22'h5, 0, 1'b1);
        fread(a ^ 22'h8, 0, 1'b0);
        // Dropping keep-select lets chip select rise before the next access
        wr(REG_CTRL, 32'h0);
        wr(REG_CTRL, 32'h20);
        fread(a ^ 22'h9, 0, 1'b0);
        wr(REG_CTRL, 32'h1);
        fread(22'h0, 1, 1'b0);
        fread(22'h3fffff, 1, 1'b0);
        a = $random(seed);
        fread(a, 1, 1'b0);
        wr(REG_CTRL, 32'h8);
        fread(a, 2, 1'b0);
        wr(REG_CTRL, 32'h6);
        #1 `chk({boost, wp_n, sc}, 3'b101);
        wr(REG_CTRL, 32'h0);
        #1 `chk({boost, wp_n, sc}, 3'b010);
        a = $random(seed);
        wr(REG_ADDR, {10'h0, a});
        wr(REG_WDATA, 32'h5aa5);
        wr(REG_CMD, {30'h0, CMD_WRITE});
        wr(REG_WDATA, 32'h0);
        rv = 32'h0;
        wait_done();
        `chk(cmd, {a, 16'h5aa5});
        rd(REG_WDATA);
        `chk(rv[15:0], 16'h5aa5);
        wr(REG_WBCNT, 32'h7f);
        rd(REG_STATUS);
        `chk(rv[ST_WBERR], 1'b0);
        wr(REG_WBCNT, 32'h80);
        rd(REG_STATUS);
        `chk(rv[ST_WBERR], 1'b1);
        wr(REG_CTRL, 32'h10);
        repeat (4) @(posedge clk);
        #1 `chk({frst_n, dq_oe}, 17'h00000);
        wr(REG_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        fread(a, 0, 1'b0);
        stop_test();
    end
    initial
    begin
        #200000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire

// >>> rtl/nfh_pkg.sv
// Package for the NOR flash host controller: register map, fields, timing
`default_nettype none
package nfh_pkg;
    localparam int CLK_MHZ          = 125;
    localparam int ADDR_W           = 22;
    localparam int DATA_W           = 16;
    // Access delays in ns; SYNC_EXTRA is in clock cycles
    localparam int ADDR_TO_DATA_NS  = 70;
    localparam int OUTEN_TO_DATA_NS = 25;
    localparam int IN_PAGE_NS       = 15;
    localparam int WE_PULSE_NS      = 35;
    localparam int WE_HIGH_NS       = 20;
    localparam int SETUP_NS         = 10;
    localparam int SYNC_EXTRA       = 2;
    // Least times round up
    localparam int ACC_CYC  = (ADDR_TO_DATA_NS * CLK_MHZ + 999) / 1000 + SYNC_EXTRA;
    localparam int OE_CYC   = (OUTEN_TO_DATA_NS * CLK_MHZ + 999) / 1000 + SYNC_EXTRA;
    localparam int PAGE_CYC = (IN_PAGE_NS * CLK_MHZ + 999) / 1000 + SYNC_EXTRA;
    localparam int WEP_CYC  = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int WEH_CYC  = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int SU_CYC   = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W    = 8;
    // Page geometry and write-buffer limit
    localparam int PAGE_LSB         = 3;
    localparam int WBUF_MAX_WORDS   = 128;
    // Register offsets (word index on the soft port)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_WDATA  = 4'h2;
    localparam logic [3:0] REG_RDATA  = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CMD    = 4'h5;
    localparam logic [3:0] REG_WBCNT  = 4'h6;
    // CTRL fields
    localparam int CTRL_BYTE   = 0;
    localparam int CTRL_BOOST  = 1;
    localparam int CTRL_PROT   = 2;
    localparam int CTRL_AUTOHV = 3;
    localparam int CTRL_RESET  = 4;
    localparam int CTRL_KEEPCE = 5;
    localparam logic [5:0] CTRL_RST_VAL = 6'h00;
    // CMD codes written to REG_CMD
    localparam logic [1:0] CMD_READ  = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    // STATUS fields
    localparam int ST_BUSY  = 0;
    localparam int ST_DONE  = 1;
    localparam int ST_FAST  = 2;
    localparam int ST_WBERR = 3;
    typedef enum logic [2:0] {
        NFH_IDLE, NFH_SETUP, NFH_RD_WAIT, NFH_WE_LOW, NFH_WE_HIGH, NFH_RST
    } nfh_state_t;
endpackage
`default_nettype wire

// >>> rtl/nfh_regs.sv
// Software register file of the NOR flash host controller
`default_nettype none
module nfh_regs
    import nfh_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             boost_en,
    output logic             prot_low,
    output logic             autosel_hv,
    nfh_req_if.regs          rq
);
    logic [5:0]        ctrl_r, ctrl_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic              done_r, done_nxt;
    logic              wberr_r, wberr_nxt;
    logic [7:0]        wbcnt_r, wbcnt_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic              start_c, is_wr_c;

    always_comb
    begin
        ctrl_nxt  = ctrl_r;
        addr_nxt  = addr_r;
        wdata_nxt = wdata_r;
        wbcnt_nxt = wbcnt_r;
        wberr_nxt = wberr_r;
        start_c   = 1'b0;
        is_wr_c   = 1'b0;
        rdata_nxt = 32'h0;
        // Done is sticky; a new completion beats the software clear
        done_nxt  = done_r;
        if (reg_wr && !rq.busy)
        begin
            unique case (reg_addr)
                REG_CTRL:  ctrl_nxt  = reg_wdata[5:0];
                REG_ADDR:  addr_nxt  = reg_wdata[ADDR_W-1:0];
                REG_WDATA: wdata_nxt = reg_wdata[DATA_W-1:0];
                REG_STATUS:
                begin
                    if (reg_wdata[ST_DONE])  done_nxt  = 1'b0;
                    if (reg_wdata[ST_WBERR]) wberr_nxt = 1'b0;
                end
                REG_WBCNT: wbcnt_nxt = reg_wdata[7:0];
                REG_CMD:
                begin
                    start_c = (reg_wdata[1:0] == CMD_READ) || (reg_wdata[1:0] == CMD_WRITE);
                    is_wr_c = (reg_wdata[1:0] == CMD_WRITE);
                    done_nxt = 1'b0;
                end
                default: ;
            endcase
        end
        // Word count above the write-buffer limit is flagged, not clipped
        if (reg_wr && reg_addr == REG_WBCNT && reg_wdata[7:0] > 8'(WBUF_MAX_WORDS - 1))
            wberr_nxt = 1'b1;
        if (rq.done)
            done_nxt = 1'b1;
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL:   rdata_nxt = {26'h0, ctrl_r};
                REG_ADDR:   rdata_nxt = {10'h0, addr_r};
                REG_WDATA:  rdata_nxt = {16'h0, wdata_r};
                REG_RDATA:  rdata_nxt = {16'h0, rq.rdata};
                REG_STATUS: rdata_nxt = {28'h0, wberr_r, rq.fast, done_r, rq.busy};
                REG_WBCNT:  rdata_nxt = {24'h0, wbcnt_r};
                default:    rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_r  <= CTRL_RST_VAL;
            addr_r  <= '0;
            wdata_r <= '0;
            done_r  <= 1'b0;
            wberr_r <= 1'b0;
            wbcnt_r <= 8'h00;
            rdata_r <= 32'h0;
        end
        else
        begin
            ctrl_r  <= ctrl_nxt;
            addr_r  <= addr_nxt;
            wdata_r <= wdata_nxt;
            done_r  <= done_nxt;
            wberr_r <= wberr_nxt;
            wbcnt_r <= wbcnt_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata    = rdata_r;
    assign rq.start     = start_c;
    assign rq.is_write  = is_wr_c;
    assign rq.addr      = addr_r;
    assign rq.wdata     = wdata_r;
    assign rq.byte_mode = ctrl_r[CTRL_BYTE];
    assign rq.keep_ce   = ctrl_r[CTRL_KEEPCE];
    assign rq.hw_reset  = ctrl_r[CTRL_RESET];
    assign boost_en     = ctrl_r[CTRL_BOOST];
    assign prot_low     = ctrl_r[CTRL_PROT];
    assign autosel_hv   = ctrl_r[CTRL_AUTOHV];
endmodule
`default_nettype wire

// >>> rtl/nfh_req_if.sv
// Request/answer carrier between register file and pin sequencer
`default_nettype none
interface nfh_req_if;
    import nfh_pkg::*;
    logic              start;
    logic              is_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              byte_mode;
    logic              keep_ce;
    logic              hw_reset;
    logic              busy;
    logic              done;
    logic              fast;
    logic [DATA_W-1:0] rdata;
    modport regs (output start, is_write, addr, wdata, byte_mode, keep_ce, hw_reset,
                  input busy, done, fast, rdata);
    modport seq  (input start, is_write, addr, wdata, byte_mode, keep_ce, hw_reset,
                  output busy, done, fast, rdata);
endinterface
`default_nettype wire

// >>> rtl/nfh_seq.sv
// Pin sequencer: drives one read or write cycle on the flash pins
`default_nettype none
module nfh_seq
    import nfh_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    nfh_req_if.seq                 rq,
    input  wire logic [DATA_W-1:0] dq_sync,
    output logic                   ce_n,
    output logic                   oe_n,
    output logic                   we_n,
    output logic                   reset_n,
    output logic                   byte_n,
    output logic      [ADDR_W-1:0] a_out,
    output logic      [DATA_W-1:0] dq_o,
    output logic      [DATA_W-1:0] dq_oe
);
    nfh_state_t        st_r, st_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    logic              ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
    logic              drv_r, drv_nxt, wr_r, wr_nxt, byte_r, byte_nxt;
    logic              pg_ok_r, pg_ok_nxt, fast_r, fast_nxt, done_r, done_nxt;
    logic [ADDR_W-1:0] a_r, a_nxt;
    logic [DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic              same_page;

    assign same_page = (rq.addr[ADDR_W-1:PAGE_LSB] == a_r[ADDR_W-1:PAGE_LSB]);

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ce_n_nxt = ce_n_r;
        oe_n_nxt = oe_n_r;
        we_n_nxt = we_n_r;
        drv_nxt = drv_r;
        wr_nxt = wr_r;
        byte_nxt = byte_r;
        pg_ok_nxt = pg_ok_r;
        fast_nxt = fast_r;
        done_nxt = 1'b0;
        a_nxt = a_r;
        wd_nxt = wd_r;
        rd_nxt = rd_r;
        unique case (st_r)
            NFH_IDLE:
            begin
                if (rq.hw_reset)
                begin
                    // Device ignores strobes while held in reset
                    ce_n_nxt = 1'b1;
                    pg_ok_nxt = 1'b0;
                    st_nxt = NFH_RST;
                end
                else if (rq.start)
                begin
                    wr_nxt = rq.is_write;
                    a_nxt = rq.addr;
                    wd_nxt = rq.wdata;
                    oe_n_nxt = 1'b1;
                    we_n_nxt = 1'b1;
                    // width before select
                    // Width is settled before chip select falls and not moved while low
                    if (ce_n_r || rq.byte_mode != byte_r)
                    begin
                        ce_n_nxt = 1'b1;
                        byte_nxt = rq.byte_mode;
                        pg_ok_nxt = 1'b0;
                    end
                    fast_nxt = !rq.is_write && pg_ok_r && same_page
                               && !ce_n_r && rq.byte_mode == byte_r;
                    cnt_nxt = CNT_W'(SU_CYC);
                    st_nxt = NFH_SETUP;
                end
                else if (!rq.keep_ce)
                begin
                    // A deselect forces the next access to take the full delay
                    ce_n_nxt = 1'b1;
                    pg_ok_nxt = 1'b0;
                end
            end
            NFH_SETUP:
            begin
                ce_n_nxt = 1'b0;
                if (cnt_r > 1)
                    cnt_nxt = cnt_r - 1'b1;
                else if (wr_r)
                begin
                    we_n_nxt = 1'b0;
                    drv_nxt = 1'b1;
                    cnt_nxt = CNT_W'(WEP_CYC);
                    st_nxt = NFH_WE_LOW;
                end
                else
                begin
                    oe_n_nxt = 1'b0;
                    // Enable delay can outlast the page delay, so a page hit waits for both
                    cnt_nxt = fast_r ? CNT_W'((PAGE_CYC > OE_CYC) ? PAGE_CYC : OE_CYC)
                                     : CNT_W'((ACC_CYC > OE_CYC) ? ACC_CYC : OE_CYC);
                    st_nxt = NFH_RD_WAIT;
                end
            end
            NFH_RD_WAIT:
            begin
                // Sample no earlier than the later of address and enable delays
                if (cnt_r > 1)
                    cnt_nxt = cnt_r - 1'b1;
                else
                begin
                    rd_nxt = byte_r ? {8'h00, dq_sync[7:0]} : dq_sync;
                    oe_n_nxt = 1'b1;
                    pg_ok_nxt = 1'b1;
                    done_nxt = 1'b1;
                    st_nxt = NFH_IDLE;
                end
            end
            NFH_WE_LOW:
            begin
                if (cnt_r > 1)
                    cnt_nxt = cnt_r - 1'b1;
                else
                begin
                    we_n_nxt = 1'b1;
                    cnt_nxt = CNT_W'(WEH_CYC);
                    st_nxt = NFH_WE_HIGH;
                end
            end
            NFH_WE_HIGH:
            begin
                if (cnt_r > 1)
                    cnt_nxt = cnt_r - 1'b1;
                else
                begin
                    drv_nxt = 1'b0;
                    pg_ok_nxt = 1'b0;
                    done_nxt = 1'b1;
                    st_nxt = NFH_IDLE;
                end
            end
            NFH_RST:
            begin
                if (!rq.hw_reset)
                    st_nxt = NFH_IDLE;
            end
            default: st_nxt = NFH_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= NFH_IDLE;
            cnt_r <= '0;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            drv_r <= 1'b0;
            wr_r <= 1'b0;
            byte_r <= 1'b0;
            pg_ok_r <= 1'b0;
            fast_r <= 1'b0;
            done_r <= 1'b0;
            a_r <= '0;
            wd_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ce_n_r <= ce_n_nxt;
            oe_n_r <= oe_n_nxt;
            we_n_r <= we_n_nxt;
            drv_r <= drv_nxt;
            wr_r <= wr_nxt;
            byte_r <= byte_nxt;
            pg_ok_r <= pg_ok_nxt;
            fast_r <= fast_nxt;
            done_r <= done_nxt;
            a_r <= a_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
        end
    end

    assign ce_n = ce_n_r;
    assign oe_n = oe_n_r;
    assign we_n = we_n_r;
    assign reset_n = !(st_r == NFH_RST);
    // Byte pin high selects word width
    assign byte_n = !byte_r;
    assign a_out = a_r;
    // In byte mode pin 15 carries the lowest address bit
    assign dq_o = byte_r ? {a_r[0], 7'h00, wd_r[7:0]} : wd_r;
    assign dq_oe = byte_r ? {1'b1, 7'h00, {8{drv_r}}} : {DATA_W{drv_r}};
    // Held flash reset is not busy, so software can still clear the reset bit
    assign rq.busy = (st_r != NFH_IDLE) && (st_r != NFH_RST);
    assign rq.done = done_r;
    assign rq.fast = fast_r;
    assign rq.rdata = rd_r;

    // Read never overlaps a write strobe
    rd_we_excl_a: assert property (@(posedge clk) disable iff (rst) !(!oe_n && !we_n))
        else $error("output enable and write enable low together");
    // Write strobe only with chip select low and output enable high
    wr_strobe_a: assert property (@(posedge clk) disable iff (rst)
        !we_n |-> (!ce_n && oe_n)) else $error("bad write strobe levels");
    // In word mode, data not driven while output enable is low
    dq_drive_a: assert property (@(posedge clk) disable iff (rst)
        (!byte_r && dq_oe != '0) |-> oe_n) else $error("driving bus during read");
    // Output enable held low at least 4 cycles on a non-page access
    full_wait_a: assert property (@(posedge clk) disable iff (rst)
        ($fell(oe_n) && !fast_r) |-> !oe_n [*4]) else $error("read too short");
    // Width pin steady while selected
    byte_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!ce_n && !$past(ce_n)) |-> $stable(byte_n)) else $error("width moved");
    // Reset pin holds chip deselected
    rst_float_a: assert property (@(posedge clk) disable iff (rst)
        !reset_n |-> (ce_n && oe_n && we_n)) else $error("strobe under reset");
    // Page hit only after a completed read with chip kept selected
    fast_src_a: assert property (@(posedge clk) disable iff (rst)
        $rose(fast_r) |-> $past(pg_ok_r)) else $error("fast access without page");
    // Write pulse length
    we_pulse_a: assert property (@(posedge clk) disable iff (rst)
        $fell(we_n) |-> !we_n [*5]) else $error("write pulse too short");
endmodule
`default_nettype wire

// >>> rtl/nfh_top.sv
// Host controller for an asynchronous NOR flash parallel port
`default_nettype none
module nfh_top
    import nfh_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    output logic                   chip_enable_n,
    output logic                   output_enable_n,
    output logic                   write_enable_n,
    output logic                   flash_reset_n,
    output logic                   width_select_n,
    output logic                   program_boost_pin,
    output logic                   write_protect_n,
    output logic                   autoselect_hv_en,
    output logic      [ADDR_W-1:0] flash_addr,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic      [DATA_W-1:0] dq_oe
);
    nfh_req_if rq ();
    logic [DATA_W-1:0] dq_s1_r, dq_s2_r;
    logic              boost_en, prot_low, autosel_hv;

    // Two-stage capture of the asynchronous data bus
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
        end
        else
        begin
            dq_s1_r <= dq_i;
            dq_s2_r <= dq_s1_r;
        end
    end

    nfh_regs u_regs (
        .clk        (clk),
        .rst        (rst),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .boost_en   (boost_en),
        .prot_low   (prot_low),
        .autosel_hv (autosel_hv),
        .rq         (rq.regs)
    );

    nfh_seq u_seq (
        .clk     (clk),
        .rst     (rst),
        .rq      (rq.seq),
        .dq_sync (dq_s2_r),
        .ce_n    (chip_enable_n),
        .oe_n    (output_enable_n),
        .we_n    (write_enable_n),
        .reset_n (flash_reset_n),
        .byte_n  (width_select_n),
        .a_out   (flash_addr),
        .dq_o    (dq_o),
        .dq_oe   (dq_oe)
    );

    assign program_boost_pin = boost_en;
    assign write_protect_n   = !prot_low;
    assign autoselect_hv_en  = autosel_hv;
endmodule
`default_nettype wire
